/* File: sar_conversion_sequencer.sv */
`timescale 1ns/1ns
module sar_conversion_sequencer #(
    parameter int DATA_W = sar_seq_pkg::DATA_BITS,
    parameter int STEP_CYC = sar_seq_pkg::STEP_CYCLES,
    parameter int DONE_CYC = sar_seq_pkg::DONE_SET_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic select_n_i,
    input wire logic start_n_i,
    input wire logic read_n_i,
    input wire logic compare_i,
    output logic [DATA_W-1:0] trial_code_o,
    output logic sample_pos_o,
    output logic sample_neg_o,
    output logic conversion_done_n_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o
);
    localparam int DIV_W = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
    localparam int CNT_W = $clog2(DONE_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CYC - 1);
    localparam logic [DIV_W-1:0] POS_PHASE = DIV_W'(sar_seq_pkg::POS_SAMPLE_PHASE);
    localparam logic [DIV_W-1:0] NEG_PHASE = DIV_W'(sar_seq_pkg::NEG_SAMPLE_PHASE);
    localparam logic [CNT_W-1:0] DONE_LOAD = CNT_W'(DONE_CYC);
    localparam logic [DATA_W-1:0] MSB_TRIAL = {1'b1, {(DATA_W-1){1'b0}}};
    localparam logic [DATA_W-1:0] ZERO_W = {DATA_W{1'b0}};
    localparam int STEP_W = $clog2(DATA_W + 1);
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(DATA_W - 1);

    sar_seq_pkg::seq_state_e state_r;
    sar_seq_pkg::seq_state_e state_nxt;
    logic [DIV_W-1:0] div_r;
    logic first_stage_flop_r;
    logic [DATA_W-1:0] shift_r;
    logic [DATA_W-1:0] approximation_register_r;
    logic [DATA_W-1:0] data_r;
    logic [CNT_W-1:0] set_cnt_r;
    logic done_ff_r;
    logic tick;
    logic start_cond;
    logic read_cond;
    logic start_clear_gate;
    logic result_transfer_gate;
    logic set_active;
    logic [DATA_W-1:0] resolved;
    logic [STEP_W-1:0] step_cnt_r;

    // Keeps or drops the trial bit under the marker
    function automatic logic [DATA_W-1:0] resolve_bit(
        input logic [DATA_W-1:0] code,
        input logic [DATA_W-1:0] marker,
        input logic keep
    );
        resolve_bit = keep ? code : (code & ~marker);
    endfunction

    // Active-low controls
    assign start_cond = !select_n_i && !start_n_i;
    assign read_cond = !select_n_i && !read_n_i;
    assign tick = (div_r == DIV_LAST);
    assign start_clear_gate = first_stage_flop_r && tick;
    assign result_transfer_gate = (state_r == sar_seq_pkg::ST_CONV) && tick && shift_r[0];
    assign set_active = (set_cnt_r != {CNT_W{1'b0}});
    assign resolved = resolve_bit(approximation_register_r, shift_r, compare_i);

    // Sequencing phase divider
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            div_r <= {DIV_W{1'b0}};
        end else if (tick) begin
            div_r <= {DIV_W{1'b0}};
        end else begin
            div_r <= div_r + DIV_W'(1);
        end
    end

    // Sequencer state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sar_seq_pkg::ST_IDLE: begin
                if (start_cond) begin
                    state_nxt = sar_seq_pkg::ST_ARMED;
                end
            end
            sar_seq_pkg::ST_ARMED: begin
                if (start_clear_gate && !start_cond) begin
                    state_nxt = sar_seq_pkg::ST_CONV;
                end
            end
            sar_seq_pkg::ST_CONV: begin
                if (start_cond) begin
                    state_nxt = sar_seq_pkg::ST_ARMED;
                end else if (result_transfer_gate) begin
                    state_nxt = sar_seq_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = sar_seq_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r <= sar_seq_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // First stage flop
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            first_stage_flop_r <= 1'b0;
        end else if (start_cond || state_r == sar_seq_pkg::ST_ARMED) begin
            first_stage_flop_r <= !(start_clear_gate && !start_cond);
        end else begin
            first_stage_flop_r <= 1'b0;
        end
    end

    // Marker shift register and approximation register
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            shift_r <= ZERO_W;
            approximation_register_r <= ZERO_W;
        end else if (start_cond) begin
            shift_r <= ZERO_W;
            approximation_register_r <= ZERO_W;
        end else if (state_r == sar_seq_pkg::ST_ARMED) begin
            if (start_clear_gate) begin
                shift_r <= MSB_TRIAL;
                approximation_register_r <= MSB_TRIAL;
            end else begin
                shift_r <= ZERO_W;
                approximation_register_r <= ZERO_W;
            end
        end else if (state_r == sar_seq_pkg::ST_CONV && tick) begin
            shift_r <= shift_r >> 1;
            approximation_register_r <= resolved | (shift_r >> 1);
        end
    end

    // Output data latch
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            data_r <= ZERO_W;
        end else if (result_transfer_gate) begin
            data_r <= resolved;
        end
    end

    // Done set pulse, loaded on the same edge as the data latch
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            set_cnt_r <= {CNT_W{1'b0}};
        end else if (start_cond || state_r == sar_seq_pkg::ST_ARMED) begin
            set_cnt_r <= {CNT_W{1'b0}};
        end else if (result_transfer_gate) begin
            set_cnt_r <= DONE_LOAD;
        end else if (set_active) begin
            set_cnt_r <= set_cnt_r - CNT_W'(1);
        end
    end

    // Done flop: set wins over read clear, start (armed state) clear wins over set
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            done_ff_r <= 1'b0;
        end else if (set_active && state_r != sar_seq_pkg::ST_ARMED) begin
            done_ff_r <= 1'b1;
        end else if (read_cond || state_r == sar_seq_pkg::ST_ARMED) begin
            done_ff_r <= 1'b0;
        end
    end

    // Comparisons completed in the running conversion
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            step_cnt_r <= {STEP_W{1'b0}};
        end else if (state_r != sar_seq_pkg::ST_CONV) begin
            step_cnt_r <= {STEP_W{1'b0}};
        end else if (tick) begin
            step_cnt_r <= step_cnt_r + STEP_W'(1);
        end
    end

    assign conversion_done_n_o = !done_ff_r;
    assign trial_code_o = approximation_register_r;
    assign data_o = data_r;
    assign data_oe_o = read_cond;
    assign sample_pos_o = (state_r == sar_seq_pkg::ST_CONV) && (div_r == POS_PHASE);
    assign sample_neg_o = (state_r == sar_seq_pkg::ST_CONV) && (div_r == NEG_PHASE);

    AST_CONV_LEN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        result_transfer_gate |-> $past(state_r, 63) == sar_seq_pkg::ST_CONV
            && $past(state_r, 64) != sar_seq_pkg::ST_CONV)
        else $error("Conversion did not take 64 clocks");

    AST_MSB_FIRST: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(state_r == sar_seq_pkg::ST_CONV) |-> approximation_register_r == MSB_TRIAL)
        else $error("First trial is not the top bit");

    AST_DONE_AFTER_DATA: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        result_transfer_gate ##1 (!start_cond && state_r != sar_seq_pkg::ST_ARMED)
            |-> data_r == $past(resolved) ##1 !conversion_done_n_o)
        else $error("Done did not follow the data latch by one clock");

    AST_RESET_HOLD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        start_cond |=> state_r == sar_seq_pkg::ST_ARMED && shift_r == ZERO_W
            && approximation_register_r == ZERO_W)
        else $error("Sequencer not held in reset while start is low");

    AST_START_LATENCY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $fell(start_cond) && state_r == sar_seq_pkg::ST_ARMED
            |-> ##[1:8] (state_r == sar_seq_pkg::ST_CONV || start_cond))
        else $error("Conversion did not begin within 8 clocks");

    AST_DONE_SET_LEN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(set_active) ##0 (!start_cond && state_r != sar_seq_pkg::ST_ARMED)[*8]
            |-> set_active && $past(set_cnt_r, 7) == DONE_LOAD ##1 !set_active)
        else $error("Done set pulse length wrong");

    AST_SET_WINS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        set_active && state_r != sar_seq_pkg::ST_ARMED |=> !conversion_done_n_o)
        else $error("Done not low during set pulse");

    AST_READ_CLEARS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        read_cond && !set_active |=> conversion_done_n_o)
        else $error("Read did not clear done");

    AST_FREE_RUN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        start_cond && done_ff_r |-> ##2 conversion_done_n_o)
        else $error("Start did not release done");

    AST_NEG_SAMPLE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        sample_pos_o ##1 (state_r == sar_seq_pkg::ST_CONV)[*5] |-> sample_neg_o)
        else $error("Negative input sample skew wrong");

    AST_TRIAL: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        state_r == sar_seq_pkg::ST_CONV && tick && !start_cond
            |=> (approximation_register_r & $past(shift_r))
                == ($past(compare_i) ? $past(shift_r) : ZERO_W))
        else $error("Trial bit not resolved from comparator");

    AST_EIGHT_STEPS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        result_transfer_gate |-> step_cnt_r == STEP_LAST)
        else $error("Conversion did not take eight comparisons");

    AST_MARKER_ONEHOT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        state_r == sar_seq_pkg::ST_CONV |-> $onehot(shift_r))
        else $error("Marker is not a single one");

    AST_LOW_BITS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        state_r == sar_seq_pkg::ST_CONV
            |-> (approximation_register_r & (shift_r - DATA_W'(1))) == ZERO_W)
        else $error("Bits below the marker are set");

    AST_DATA_HOLD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !result_transfer_gate |=> data_r == $past(data_r))
        else $error("Output latch changed outside a transfer");

    AST_ARMED_CLEARS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        state_r == sar_seq_pkg::ST_ARMED |=> conversion_done_n_o)
        else $error("Start did not clear done");

    AST_DONE_STAYS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        done_ff_r && !read_cond && state_r != sar_seq_pkg::ST_ARMED |=> !conversion_done_n_o)
        else $error("Done released without read or start");

    AST_OE_OFF: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        select_n_i || read_n_i |-> !data_oe_o)
        else $error("Data driven while not selected for read");

    AST_OE_ON: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !select_n_i && !read_n_i |-> data_oe_o)
        else $error("Data not driven during read");

    AST_IDLE_QUIET: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        state_r != sar_seq_pkg::ST_CONV |-> !sample_pos_o && !sample_neg_o)
        else $error("Input sampled outside conversion");

    AST_DATA_ON_DONE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $fell(conversion_done_n_o) && state_r != sar_seq_pkg::ST_ARMED
            |-> data_o == trial_code_o)
        else $error("Latched result differs from resolved code");

    AST_FIRST_STAGE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        start_cond |=> first_stage_flop_r)
        else $error("Start did not load the first stage");

    AST_MARKER_LEAVES: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        result_transfer_gate |=> shift_r == ZERO_W)
        else $error("Marker still in shift register after transfer");

    AST_SET_FROM_TRANSFER: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(set_active) |-> $past(result_transfer_gate))
        else $error("Done set pulse without a transfer");

    COV_COMPLETE: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        result_transfer_gate);
    COV_ABORT: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        state_r == sar_seq_pkg::ST_CONV && start_cond);
    COV_READ_HELD: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        set_active && read_cond);
    COV_FREE_RUN: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !conversion_done_n_o && start_cond);
    COV_WIDE_START: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        start_clear_gate && start_cond);
endmodule

/* File: sar_seq_pkg.sv */
// What this block does
// - MSB tested first; eight comparisons in 64 clocks; latch result, then assert done.
// - Result is straight binary, all ones meaning full-scale differential input.
// - A new start during conversion aborts it and begins a fresh one.
// - Free-running: select low, done wired to start, each done fall restarts.
// - Start falling edge clears approximation register and all shift stages.
// - While select and start are both low, sequencer stays in reset.
// - Conversion begins 1 to 8 clocks after select or start returns high.
// - Start flop clears shift register and done flop, loads one into first stage.
// - Start clear pulse is ignored while start persists; wide strobes tolerated.
// - Marker leaving last stage loads output latch; end latch then sets done.
// - Sequencing phases run at one eighth of clock; done set lasts 8 clocks.
// - With reading held on, done still falls and stays low 8 clocks.
// - Free-running: falling done sets start flop, releasing done quickly.
// - Select and output enable low clear done and drive result outputs.
// - Select, start and read inputs active low, reset active high; select may be tied low standalone.
// - Negative input sampled five clocks after positive input.
// - Output data latch updates one clock before done asserts.
package sar_seq_pkg;
    localparam int DATA_BITS = 8;
    localparam int CONV_CYCLES = 64;
    localparam int STEP_CYCLES = CONV_CYCLES / DATA_BITS;
    localparam int SEQ_DIVIDE = 16;
    localparam int DONE_SET_CYCLES = SEQ_DIVIDE / 2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAMPLE_SKEW_HALF_PERIODS = 9;
    localparam int SAMPLE_SKEW_CYCLES = (SAMPLE_SKEW_HALF_PERIODS + 1) / 2;
    localparam int POS_SAMPLE_PHASE = 0;
    localparam int NEG_SAMPLE_PHASE = POS_SAMPLE_PHASE + SAMPLE_SKEW_CYCLES;
    localparam logic [DATA_BITS-1:0] FULL_SCALE = 8'hFF;
    localparam logic [DATA_BITS-1:0] ZERO_CODE = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_CONV = 3'b100
    } seq_state_e;
endpackage

/* File: sar_host_model.sv */
`timescale 1ns/1ns
module sar_host_model (
    input wire logic [7:0] trial_code_i,
    input wire logic [7:0] level_i,
    input wire logic free_run_i,
    input wire logic done_n_i,
    input wire logic start_req_n_i,
    output logic compare_o,
    output logic start_n_o
);
    // Ideal comparator against the held input level
    assign compare_o = (level_i >= trial_code_i);
    // Explicit strobe, or done fed back in free-run
    assign start_n_o = start_req_n_i & (done_n_i | !free_run_i);
endmodule

/* File: sar_conversion_sequencer_tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD %0t mismatch", $time); end end
module sar_conversion_sequencer_tb_top;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic select_n_i = 1'b1;
    logic start_req_n = 1'b1;
    logic read_n_i = 1'b1;
    logic free_run = 1'b0;
    logic [7:0] level = 8'h00;
    logic start_n_i;
    logic compare_i;
    logic [7:0] trial_code_o;
    logic [7:0] data_o;
    logic sample_pos_o;
    logic sample_neg_o;
    logic conversion_done_n_o;
    logic data_oe_o;
    int error_cnt = 0;
    int check_count = 0;
    int cyc;
    sar_conversion_sequencer DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .select_n_i(select_n_i), .start_n_i(start_n_i), .read_n_i(read_n_i),
        .compare_i(compare_i), .trial_code_o(trial_code_o), .sample_pos_o(sample_pos_o),
        .sample_neg_o(sample_neg_o), .conversion_done_n_o(conversion_done_n_o),
        .data_o(data_o), .data_oe_o(data_oe_o));
    sar_host_model host (.trial_code_i(trial_code_o), .level_i(level),
        .free_run_i(free_run), .done_n_i(conversion_done_n_o),
        .start_req_n_i(start_req_n), .compare_o(compare_i), .start_n_o(start_n_i));
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // Start strobe with chip select, then release start only; select stays low
    task automatic start_pulse(input int width);
        select_n_i = 1'b0;
        start_req_n = 1'b0;
        tick(width);
        start_req_n = 1'b1;
    endtask
    // Count cycles until done falls; bound exhausted ends the run
    task automatic wait_done(output int n);
        for (n = 1; n <= 200; n++) begin
            tick(1);
            if (conversion_done_n_o === 1'b0) return;
        end
        error_cnt++;
        $display("BAD %0t done never fell", $time);
        end_of_test();
    endtask
    // One conversion, optionally with reading held on throughout
    task automatic convert(input logic [7:0] lvl, input logic reading);
        level = lvl;
        read_n_i = !reading;
        start_pulse(2);
        `CHK(trial_code_o, 8'h00)
        `CHK(conversion_done_n_o, 1'b1)
        wait_done(cyc);
        `CHK(cyc >= 64 && cyc <= 75, 1'b1)
        `CHK(data_o, lvl)
        tick(7);
        `CHK(conversion_done_n_o, 1'b0)
        read_n_i = 1'b0;
        #1;
        `CHK(data_oe_o, 1'b1)
        `CHK(data_o, lvl)
        tick(3);
        `CHK(conversion_done_n_o, 1'b1)
        read_n_i = 1'b1;
        #1;
        `CHK(data_oe_o, 1'b0)
        tick(1);
        select_n_i = 1'b1;
        read_n_i = 1'b0;
        #1;
        `CHK(data_oe_o, 1'b0)
        tick(1);
        read_n_i = 1'b1;
        tick(1);
    endtask
    // Wide strobe holds reset; restart mid-conversion
    task automatic hold_and_abort();
        int n;
        level = 8'h3C;
        select_n_i = 1'b0;
        start_req_n = 1'b0;
        tick(100);
        `CHK(trial_code_o, 8'h00)
        `CHK(conversion_done_n_o, 1'b1)
        start_req_n = 1'b1;
        for (n = 0; n < 10 && sample_pos_o !== 1'b1; n++) begin
            tick(1);
        end
        `CHK(sample_pos_o, 1'b1)
        if (sample_pos_o !== 1'b1) begin
            end_of_test();
        end
        `CHK(trial_code_o, 8'h80)
        tick(5);
        `CHK(sample_neg_o, 1'b1)
        `CHK(sample_pos_o, 1'b0)
        tick(15);
        level = 8'h96;
        start_pulse(1);
        wait_done(cyc);
        `CHK(data_o, 8'h96)
        `CHK(cyc >= 64, 1'b1)
    endtask
    // Free-running: done fed back to start, short done pulses
    task automatic free_running();
        int falls;
        int low;
        falls = 0;
        low = 0;
        level = 8'h5A;
        free_run = 1'b1;
        start_pulse(1);
        for (int i = 0; i < 300; i++) begin
            tick(1);
            if (conversion_done_n_o === 1'b0) begin
                low++;
                if (low == 1) falls++;
            end else begin
                if (low > 0) `CHK(low <= 3, 1'b1)
                low = 0;
            end
        end
        `CHK(falls >= 3, 1'b1)
        free_run = 1'b0;
    endtask
    initial begin
        tick(20);
        sys_rst_i = 1'b0;
        `CHK(conversion_done_n_o, 1'b1)
        `CHK(data_oe_o, 1'b0)
        convert(8'hFF, 1'b0);
        convert(8'h00, 1'b1);
        convert(8'hA5, 1'b0);
        hold_and_abort();
        free_running();
        end_of_test();
    end
endmodule
